//--- core/ssp_defines.vh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the status/peek core files
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// byte offsets on the avalon bus (word aligned)
`define SSP_OFS_CONTROL   6'h00
`define SSP_OFS_STATUS    6'h04
`define SSP_OFS_PEEK      6'h08
`define SSP_OFS_RELEASE   6'h0C
`define SSP_OFS_HOLD      6'h10
`define SSP_OFS_IRQ_STAT  6'h14
`define SSP_OFS_IRQ_MASK  6'h18

// status word field positions
`define SSP_ST_BITCNT_LSB 0
`define SSP_ST_BUSY       6
`define SSP_ST_RX_EMPTY   7
`define SSP_ST_RX_FULL    8
`define SSP_ST_TX_EMPTY   9
`define SSP_ST_TX_FULL    10
`define SSP_ST_RX_LVL_LSB 12
`define SSP_ST_TX_LVL_LSB 20

// control word fields
`define SSP_CT_LEN_LSB    0
`define SSP_CT_ENABLE     6

// interrupt event bits
`define SSP_EV_DONE       0
`define SSP_EV_RX_DATA    1
`define SSP_EV_TX_EMPTY   2
`define SSP_EV_TX_DROP    3

// reset values
`define SSP_PEEK_RESET    16'h0000
`define SSP_LEN_RESET     6'h08

// minimum chip-select high time in ns and in clock cycles at 125 MHz
`define SSP_CS_HIGH_NS    40
`define SSP_CLK_MHZ       125
`define SSP_CS_HIGH_CYC   ((`SSP_CS_HIGH_NS * `SSP_CLK_MHZ + 999) / 1000)

`endif

//--- core/ssp_fifo_mem.v
// small dual-port word store for the receive queue
// assumes one clock; read data come out of a register
`timescale 1ns/1ps
module ssp_fifo_mem #(
  parameter WIDTH = 16,
  parameter AW    = 2
) (
  input  wire             i_clock,
  input  wire             i_enable,
  input  wire             i_wr,
  input  wire [AW-1:0]    i_wr_addr,
  input  wire [WIDTH-1:0] i_wr_data,
  input  wire [AW-1:0]    i_rd_addr,
  output reg  [WIDTH-1:0] o_rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // write port and registered read port
  always @(posedge i_clock) begin
    if (i_enable) begin
      if (i_wr) begin
        mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule

//--- core/ssp_status_peek.v
// How it works
// - rx empty flag set when rx queue empty
// - rx full flag set when rx queue full
// - tx full flag set when tx queue full
// - tx empty flag set when tx queue empty
// - read-only transmit queue level
// - read-only receive queue level
// - busy bit set while transferring
// - busy clears after tx empty and cs-high
// - bit counter loads length, counts down
// - peek reads rx head without popping
// - release port write deasserts cs after
// - hold port write keeps cs asserted if tx queue not empty
// - data read pops; empty returns last word
// - write to full tx queue is dropped
//
// status, peek and data ports of an auxiliary spi master with its shifter
// assumes avalon-mm slave bus on i_clock; spi pins from outside the domain
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_status_peek #(
  parameter AW        = 2,
  parameter CS_HIGH   = `SSP_CS_HIGH_CYC,
  parameter DIV_HALF  = 10
) (
  input  wire        i_clock,
  input  wire        i_reset,
  input  wire        i_enable,
  input  wire [5:0]  i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [31:0] i_writedata,
  output reg  [31:0] o_readdata,
  output wire        o_waitrequest,
  output wire        o_irq,
  output reg         o_sclk,
  output reg         o_mosi,
  input  wire        i_miso,
  output reg         o_cs_n
);
  localparam DEPTH = 1 << AW;
  localparam [AW:0] FULL_LVL = DEPTH;
  // shifter states, one-hot
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_LOAD = 4'b0010;
  localparam [3:0] S_SHIFT = 4'b0100;
  localparam [3:0] S_GAP = 4'b1000;

  // full when level equals depth
  function is_full;
    input [AW:0] lvl;
    begin
      is_full = (lvl == FULL_LVL);
    end
  endfunction

  // empty when level is zero
  function is_empty;
    input [AW:0] lvl;
    begin
      is_empty = (lvl == {(AW+1){1'b0}});
    end
  endfunction

  reg  [3:0]    state_reg;
  reg  [AW:0]   tx_lvl_reg;
  reg  [AW:0]   rx_lvl_reg;
  reg  [AW-1:0] tx_wp_reg;
  reg  [AW-1:0] tx_rp_reg;
  reg  [AW-1:0] rx_wp_reg;
  reg  [AW-1:0] rx_rp_reg;
  reg  [16:0]   tx_hold_mem [0:DEPTH-1];
  reg  [5:0]    len_reg;
  reg           en_reg;
  reg  [5:0]    bitcnt_reg;
  reg  [15:0]   shift_reg;
  reg  [15:0]   last_rx_reg;
  reg           cur_hold_reg;
  reg  [7:0]    div_reg;
  reg  [7:0]    gap_reg;
  reg  [3:0]    irq_stat_reg;
  reg  [3:0]    irq_mask_reg;
  reg  [1:0]    miso_sync_reg;
  reg           ack_reg;
  wire [15:0]   rx_head;
  wire [15:0]   rx_mem_q;
  wire          rx_push;
  wire          rx_pop;
  wire          tx_push;
  wire          tx_pop;
  wire          acc;
  wire          data_port;
  wire          tx_full;
  wire          tx_empty;
  wire          rx_full;
  wire          rx_empty;
  wire          busy;
  wire [31:0]   status_word;
  wire [3:0]    events;
  wire          miso_s;

  // queue flags come straight from the levels
  assign tx_full  = is_full(tx_lvl_reg);
  assign tx_empty = is_empty(tx_lvl_reg);
  assign rx_full  = is_full(rx_lvl_reg);
  assign rx_empty = is_empty(rx_lvl_reg);
  // busy until queue drained and cs high time served
  assign busy = ~tx_empty | (state_reg != S_IDLE);
  assign miso_s = miso_sync_reg[1];

  // bus handshake: one wait cycle, answer on second edge
  assign acc = (i_read | i_write) & ~ack_reg & i_enable;
  assign o_waitrequest = ~ack_reg;
  assign data_port = (i_address == `SSP_OFS_RELEASE) |
                     (i_address == `SSP_OFS_HOLD);
  assign tx_push = ack_reg & i_write & data_port & ~tx_full;
  assign rx_pop  = ack_reg & i_read & data_port & ~rx_empty;
  assign tx_pop  = (state_reg == S_IDLE) & en_reg & ~tx_empty;
  assign rx_push = (state_reg == S_SHIFT) & (bitcnt_reg == 6'h01) &
                   (div_reg == DIV_HALF[7:0]) & o_sclk & ~rx_full;

  // receive head is the registered memory output after pointer settles
  assign rx_head = rx_empty ? `SSP_PEEK_RESET : rx_mem_q;

  assign status_word = {4'h0, {(8-AW-1){1'b0}}, tx_lvl_reg,
                        {(8-AW-1){1'b0}}, rx_lvl_reg,
                        1'b0, tx_full, tx_empty, rx_full, rx_empty,
                        busy, bitcnt_reg};

  assign events = {tx_push == 1'b0 && ack_reg && i_write && data_port,
                   tx_pop & (tx_lvl_reg == {{AW{1'b0}}, 1'b1}),
                   rx_push,
                   (state_reg == S_GAP) && (gap_reg == 8'h01)};
  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  // receive queue storage
  ssp_fifo_mem #(
    .WIDTH (16),
    .AW    (AW)
  ) u_rx_mem (
    .i_clock   (i_clock),
    .i_enable  (i_enable),
    .i_wr      (rx_push),
    .i_wr_addr (rx_wp_reg),
    .i_wr_data ({shift_reg[14:0], miso_s}),
    .i_rd_addr (rx_pop ? rx_rp_reg + 1'b1 : rx_rp_reg),
    .o_rd_data (rx_mem_q)
  );

  // transmit queue storage: data plus hold-cs flag
  always @(posedge i_clock) begin
    if (i_enable && tx_push) begin
      tx_hold_mem[tx_wp_reg] <= {i_address == `SSP_OFS_HOLD,
                                 i_writedata[15:0]};
    end
  end

  // miso synchroniser
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      miso_sync_reg <= 2'b00;
    end else if (i_enable) begin
      miso_sync_reg <= {miso_sync_reg[0], i_miso};
    end
  end

  // bus slave: acknowledge, read mux, control and irq registers
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ack_reg      <= 1'b0;
      o_readdata   <= 32'h0000_0000;
      len_reg      <= `SSP_LEN_RESET;
      en_reg       <= 1'b0;
      irq_mask_reg <= 4'h0;
      irq_stat_reg <= 4'h0;
    end else if (i_enable) begin
      ack_reg <= acc;
      irq_stat_reg <= irq_stat_reg | events;
      if (acc && i_read) begin
        if (i_address == `SSP_OFS_CONTROL) begin
          o_readdata <= {25'h0, en_reg, len_reg};
        end else if (i_address == `SSP_OFS_STATUS) begin
          o_readdata <= status_word;
        end else if (i_address == `SSP_OFS_PEEK) begin
          o_readdata <= {16'h0000, rx_head};
        end else if (data_port) begin
          o_readdata <= {16'h0000, rx_empty ? last_rx_reg : rx_head};
        end else if (i_address == `SSP_OFS_IRQ_STAT) begin
          o_readdata <= {28'h0, irq_stat_reg};
          irq_stat_reg <= events;  // clear on read, new events win
        end else if (i_address == `SSP_OFS_IRQ_MASK) begin
          o_readdata <= {28'h0, irq_mask_reg};
        end else begin
          o_readdata <= 32'h0000_0000;
        end
      end
      if (ack_reg && i_write) begin
        if (i_address == `SSP_OFS_CONTROL) begin
          len_reg <= i_writedata[`SSP_CT_LEN_LSB+5:`SSP_CT_LEN_LSB];
          en_reg  <= i_writedata[`SSP_CT_ENABLE];
        end else if (i_address == `SSP_OFS_IRQ_MASK) begin
          irq_mask_reg <= i_writedata[3:0];
        end
      end
    end
  end

  // queue pointers and levels
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_lvl_reg <= {(AW+1){1'b0}};
      rx_lvl_reg <= {(AW+1){1'b0}};
      tx_wp_reg  <= {AW{1'b0}};
      tx_rp_reg  <= {AW{1'b0}};
      rx_wp_reg  <= {AW{1'b0}};
      rx_rp_reg  <= {AW{1'b0}};
    end else if (i_enable) begin
      if (tx_push) begin
        tx_wp_reg <= tx_wp_reg + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 1'b1;
      end
      if (tx_push != tx_pop) begin
        tx_lvl_reg <= tx_push ? tx_lvl_reg + 1'b1 : tx_lvl_reg - 1'b1;
      end
      if (rx_push) begin
        rx_wp_reg <= rx_wp_reg + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 1'b1;
      end
      if (rx_push != rx_pop) begin
        rx_lvl_reg <= rx_push ? rx_lvl_reg + 1'b1 : rx_lvl_reg - 1'b1;
      end
    end
  end

  // shifter: load word, clock bits msb first, then cs high gap unless a hold word has more queued
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_reg    <= S_IDLE;
      bitcnt_reg   <= 6'h00;
      shift_reg    <= 16'h0000;
      last_rx_reg  <= 16'h0000;
      cur_hold_reg <= 1'b0;
      div_reg      <= 8'h00;
      gap_reg      <= 8'h00;
      o_sclk       <= 1'b0;
      o_mosi       <= 1'b0;
      o_cs_n       <= 1'b1;
    end else if (i_enable) begin
      case (state_reg)
        S_IDLE: begin
          if (tx_pop) begin
            {cur_hold_reg, shift_reg} <= tx_hold_mem[tx_rp_reg];
            bitcnt_reg <= len_reg;
            state_reg  <= S_LOAD;
          end
        end
        S_LOAD: begin
          // five bits of length so that a 16-bit word is not shifted out
          shift_reg <= shift_reg << (5'd16 - len_reg[4:0]);
          o_cs_n    <= 1'b0;
          div_reg   <= 8'h00;
          state_reg <= S_SHIFT;
        end
        S_SHIFT: begin
          o_mosi <= shift_reg[15];
          if (div_reg == DIV_HALF[7:0]) begin
            div_reg <= 8'h00;
            o_sclk  <= ~o_sclk;
            if (o_sclk) begin
              shift_reg  <= {shift_reg[14:0], miso_s};
              bitcnt_reg <= bitcnt_reg - 6'h01;
              if (bitcnt_reg == 6'h01) begin
                last_rx_reg <= {shift_reg[14:0], miso_s};
                if (cur_hold_reg && !tx_empty) begin
                  state_reg <= S_IDLE;
                end else begin
                  o_cs_n    <= 1'b1;
                  gap_reg   <= CS_HIGH[7:0];
                  state_reg <= S_GAP;
                end
              end
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        S_GAP: begin
          if (gap_reg <= 8'h01) begin
            state_reg <= S_IDLE;
          end else begin
            gap_reg <= gap_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

//--- tb/ssp_status_peek_properties.sv
// handshake, pin and status-word checks for the status/peek block
// assumes it sees only the top-level ports, attached by bind below
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_status_props #(
  parameter AW      = 2,
  parameter CS_HIGH = `SSP_CS_HIGH_CYC
) (
  input wire        i_clock,
  input wire        i_reset,
  input wire        i_enable,
  input wire [5:0]  i_address,
  input wire        i_read,
  input wire        i_write,
  input wire [31:0] i_writedata,
  input wire [31:0] o_readdata,
  input wire        o_waitrequest,
  input wire        o_irq,
  input wire        o_sclk,
  input wire        o_mosi,
  input wire        i_miso,
  input wire        o_cs_n
);
  localparam DEPTH = 1 << AW;
  reg  [7:0] gap_reg;
  wire       rd_ack = i_read && !o_waitrequest;
  wire [6:0] rxl    = o_readdata[18:12];
  wire [6:0] txl    = o_readdata[26:20];
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // cycles chip-select has stayed high, saturating
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset)
      gap_reg <= 8'hFF;
    else if (!o_cs_n)
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF)
      gap_reg <= gap_reg + 8'h01;
  end
  chk_wait_one: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest) else $error("no answer after one wait state");
  chk_ack_pulse: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_no_req_ack: assert property (!(i_read || i_write) |=> o_waitrequest)
    else $error("answer without a request");
  chk_rdata_stands: assert property (!i_read |=> $stable(o_readdata))
    else $error("read data moved without a read");
  chk_cs_gap: assert property ($fell(o_cs_n) |-> gap_reg >= CS_HIGH)
    else $error("chip-select high time too short");
  chk_sclk_framed: assert property ($changed(o_sclk)
    |-> !o_cs_n || !$past(o_cs_n)) else $error("sclk moved outside frame");
  chk_unmapped_zero: assert property (rd_ack && i_address == 6'h3C
    |-> o_readdata == 32'h00000000) else $error("unmapped read not zero");
  chk_data_upper: assert property (rd_ack &&
    (i_address == `SSP_OFS_PEEK || i_address == `SSP_OFS_RELEASE)
    |-> o_readdata[31:16] == 16'h0000)
    else $error("data word upper half not zero");
  chk_flags_levels: assert property (rd_ack &&
    i_address == `SSP_OFS_STATUS
    |-> o_readdata[7] == (rxl == 0) && o_readdata[8] == (rxl == DEPTH)
    && o_readdata[9] == (txl == 0) && o_readdata[10] == (txl == DEPTH))
    else $error("status flags disagree with levels");
endmodule

bind ssp_status_peek ssp_status_props #(.AW(AW), .CS_HIGH(CS_HIGH))
  ssp_status_props_inst (.i_clock(i_clock), .i_reset(i_reset),
  .i_enable(i_enable), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_irq(o_irq), .o_sclk(o_sclk),
  .o_mosi(o_mosi), .i_miso(i_miso), .o_cs_n(o_cs_n));

//--- tb/ssp_spi_slave.sv
// spi peripheral stand-in: sends a preset word, then echoes mosi back
// assumes mode 0: mosi taken on rising sclk, miso moves on falling sclk
`timescale 1ns/1ps
module ssp_spi_slave (
  input  wire i_sclk,
  input  wire i_cs_n,
  input  wire i_mosi,
  output wire o_miso
);
  reg [15:0] sh_reg;
  reg        in_bit;
  reg        pend_reg;
  initial begin
    sh_reg   = 16'hC35A;
    in_bit   = 1'b0;
    pend_reg = 1'b0;
  end
  // msb stands from chip-select fall; a released line shows its inverse
  assign o_miso = i_cs_n ? ~sh_reg[15] : sh_reg[15];
  // take mosi on rising sclk while selected
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      in_bit   <= i_mosi;
      pend_reg <= 1'b1;
    end
  end
  // shift on falling sclk; the pending flag keeps the last bit of a frame
  // even though chip-select rises on that same edge
  always @(negedge i_sclk) begin
    if (pend_reg) begin
      sh_reg   <= {sh_reg[14:0], in_bit};
      pend_reg <= 1'b0;
    end
  end
endmodule

//--- tb/tb.sv
// self-checking bench: bus sequences on status, peek and data ports
// assumes the core files, checker and spi stand-in are compiled first
`timescale 1ns/1ps
`include "ssp_defines.vh"
module tb;
  reg         i_clock     = 1'b0;
  reg         i_reset     = 1'b1;
  reg         i_enable    = 1'b1;
  reg  [5:0]  i_address   = 6'h00;
  reg         i_read      = 1'b0;
  reg         i_write     = 1'b0;
  reg  [31:0] i_writedata = 32'h00000000;
  wire [31:0] o_readdata;
  wire        o_waitrequest, o_irq, o_sclk, o_mosi, o_cs_n, i_miso;
  integer     err_count   = 0;
  integer     check_count = 0;
  integer     rises       = 0;
  integer     n, i;
  reg  [31:0] st, pk, q;
  always #4 i_clock = ~i_clock;
  ssp_status_peek #(.AW(2), .CS_HIGH(5), .DIV_HALF(10)) ssp_status_peek_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_enable(i_enable),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_irq(o_irq), .o_sclk(o_sclk),
    .o_mosi(o_mosi), .i_miso(i_miso), .o_cs_n(o_cs_n));
  ssp_spi_slave ssp_spi_slave_inst (.i_sclk(o_sclk), .i_cs_n(o_cs_n),
    .i_mosi(o_mosi), .o_miso(i_miso));
  // count frame ends on chip-select
  always @(posedge o_cs_n) rises = rises + 1;
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input w, input [5:0] a, input [31:0] d, output [31:0] r);
    integer k;
    begin
      @(posedge i_clock);
      i_read <= !w;
      i_write <= w;
      i_address <= a;
      i_writedata <= d;
      k = 0;
      @(posedge i_clock);
      // waitrequest and read data are taken at the same rising edge
      while (o_waitrequest !== 1'b0 && k < 50) begin
        @(posedge i_clock);
        k = k + 1;
      end
      if (k == 50) err_count = err_count + 1;
      r = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // watchdog at 25000 cycles, well beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    err_count = err_count + 1;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    bus(0, `SSP_OFS_STATUS, 32'h0, st);
    check("stat", st & 32'h07F7F57F, 32'h0);
    check("empties", {st[9], st[7]}, 32'h3);
    bus(0, `SSP_OFS_PEEK, 32'h0, q);
    check("peek", q, 32'h0);
    bus(0, 6'h3C, 32'h0, q);
    check("unmap", q, 32'h0);
    $display("test reset done");
    // queue two hold words and two release words while stopped, then one more to the full queue
    bus(1, `SSP_OFS_CONTROL, 32'h08, q);
    for (i = 0; i < 5; i = i + 1) begin
      bus(1, i < 2 ? `SSP_OFS_HOLD : `SSP_OFS_RELEASE, 32'hA500 + i, q);
      bus(0, `SSP_OFS_STATUS, 32'h0, st);
      check("txlvl", (st >> 20) & 32'h7F, i < 4 ? i + 1 : 4);
      check("txfull", st[10], i >= 3);
      check("txempty", st[9], 32'h0);
    end
    check("irqmask", o_irq, 32'h0);
    bus(1, `SSP_OFS_IRQ_MASK, 32'h8, q);
    repeat (2) @(negedge i_clock);
    check("irq", o_irq, 32'h1);
    bus(0, `SSP_OFS_IRQ_STAT, 32'h0, q);
    check("irqdrop", q[3], 32'h1);
    repeat (2) @(negedge i_clock);
    check("irqclr", o_irq, 32'h0);
    $display("test fill done");
    rises = 0;
    bus(1, `SSP_OFS_CONTROL, 32'h48, q);
    bus(0, `SSP_OFS_STATUS, 32'h0, st);
    check("busy", st[6], 32'h1);
    check("bitcnt", st[5:0] > 0 && st[5:0] <= 8, 32'h1);
    // freeze the core mid-frame: with the enable low neither sclk nor chip-select may move
    i_enable <= 1'b0;
    @(posedge i_clock);
    q = {o_sclk, o_cs_n};
    repeat (40) @(posedge i_clock);
    check("freeze", {o_sclk, o_cs_n}, q);
    i_enable <= 1'b1;
    n = 0;
    while (st[6] === 1'b1 && n < 400) begin
      bus(0, `SSP_OFS_STATUS, 32'h0, st);
      n = n + 1;
    end
    check("idle", st & 32'h07F7F7FF, 32'h0000_4300);
    check("frames", rises, 32'h2);
    $display("test shift done");
    for (i = 0; i < 4; i = i + 1) begin
      bus(0, `SSP_OFS_PEEK, 32'h0, pk);
      bus(0, `SSP_OFS_STATUS, 32'h0, st);
      check("peeklvl", (st >> 12) & 32'h7F, 4 - i);
      // stand-in sends its preset word, then echoes the low mosi bytes
      check("rxdata", pk, i == 0 ? 32'h0000_00C3 : i == 1 ? 32'h0000_005A : i - 2);
      bus(0, `SSP_OFS_RELEASE, 32'h0, q);
      check("pop", q, pk);
      bus(0, `SSP_OFS_STATUS, 32'h0, st);
      check("rxlvl", (st >> 12) & 32'h7F, 3 - i);
      check("rxflags", {st[8], st[7]}, i == 3);
    end
    bus(0, `SSP_OFS_HOLD, 32'h0, pk);
    check("lastword", pk, q);
    $display("test drain done");
    give_verdict;
  end
endmodule
